// ===== rtl/lut_pkg.sv
/*
 * Shared constants and carrier types for the core address lookup table.
 * Assumes a 32-bit core address space cut into 256 slots of 16MB each,
 * and a 16GB system with four memory controllers and a 6x4 tile mesh.
 */
package lut_pkg;

    // Address split
    localparam int ADDR_W   = 32;
    localparam int INDEX_W  = 8;
    localparam int OFFSET_W = 24;
    localparam int ENTRIES  = 256;
    localparam int SEL_W    = 5;

    // Memory sizing, in MB
    localparam int SLOT_MB        = 16;
    localparam int CORE_SPACE_MB  = 4096;
    localparam int CTRL_MEM_MB    = 4096;
    localparam int CORES_PER_CTRL = 12;
    localparam int PRIV_SLOTS     = CTRL_MEM_MB / (CORES_PER_CTRL * SLOT_MB);

    // Default map slot numbers
    localparam logic [7:0] PRIV_LOW_COUNT = 8'(PRIV_SLOTS - 1);
    localparam logic [7:0] PRIV_TOP_ENTRY = 8'hff;
    localparam logic [7:0] VREG_ENTRY     = 8'hfb;
    localparam logic [7:0] CONSOLE_ENTRY  = 8'hfa;
    localparam logic [7:0] SYSCFG_FIRST   = 8'he0;
    localparam logic [7:0] SYSCFG_LAST    = 8'hf7;
    localparam logic [7:0] MSGBUF_FIRST   = 8'hc0;
    localparam logic [7:0] MSGBUF_LAST    = 8'hd7;
    localparam logic [7:0] SHARED_FIRST   = 8'h80;
    localparam logic [7:0] SHARED_LAST    = 8'h83;

    // Mesh shape
    localparam int MESH_X = 6;
    localparam int MESH_Y = 4;

    typedef enum logic [2:0] {
        DEST_NONE,
        DEST_PRIVATE,
        DEST_SHARED,
        DEST_MSGBUF,
        DEST_SYSCFG,
        DEST_VREG,
        DEST_CONSOLE
    } dest_kind_t;

    typedef struct packed {
        dest_kind_t        kind;
        logic [SEL_W-1:0]  sel;
    } lut_entry_t;

    localparam lut_entry_t ENTRY_NONE = '{DEST_NONE, 5'h00};

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
    } core_req_t;

    typedef struct packed {
        logic                valid;
        logic                fault;
        dest_kind_t          kind;
        logic [SEL_W-1:0]    sel;
        logic [1:0]          ctrl;
        logic [2:0]          tile_x;
        logic [1:0]          tile_y;
        logic [7:0]          mem_slot;
        logic [OFFSET_W-1:0] offset;
    } mesh_req_t;

endpackage

// ===== rtl/lut_default_map.sv
/*
 * Reset contents of the lookup table for the 16GB system map.
 * Pure combinational constants; the table owner loads them under reset.
 */
`timescale 1ns/1ps

module lut_default_map
    import lut_pkg::*;
(
    output lut_entry_t [ENTRIES-1:0] default_table
);

    function automatic lut_entry_t default_entry(input logic [7:0] idx);
        lut_entry_t e;
        e = ENTRY_NONE;
        if (idx < PRIV_LOW_COUNT) begin
            e = '{DEST_PRIVATE, idx[SEL_W-1:0]};
        end else if (idx == PRIV_TOP_ENTRY) begin
            e = '{DEST_PRIVATE, PRIV_LOW_COUNT[SEL_W-1:0]};
        end else if (idx == VREG_ENTRY) begin
            e = '{DEST_VREG, 5'h00};
        end else if (idx == CONSOLE_ENTRY) begin
            e = '{DEST_CONSOLE, 5'h00};
        end else if (idx >= SYSCFG_FIRST && idx <= SYSCFG_LAST) begin
            e = '{DEST_SYSCFG, 5'(idx - SYSCFG_FIRST)};
        end else if (idx >= MSGBUF_FIRST && idx <= MSGBUF_LAST) begin
            e = '{DEST_MSGBUF, 5'(idx - MSGBUF_FIRST)};
        end else if (idx >= SHARED_FIRST && idx <= SHARED_LAST) begin
            e = '{DEST_SHARED, 5'(idx - SHARED_FIRST)};
        end
        return e;
    endfunction

    // One constant entry per slot
    for (genvar i = 0; i < ENTRIES; i++) begin : g_slot
        assign default_table[i] = default_entry(8'(i));
    end

endmodule

// ===== rtl/mesh_request_former.sv
/*
 * Turns one looked-up table entry and the core address into a mesh request.
 * Combinational; the caller registers the result.
 */
`timescale 1ns/1ps

module mesh_request_former
    import lut_pkg::*;
#(
    parameter logic [1:0] HOME_CTRL    = 2'h0,
    parameter logic [3:0] CORE_IN_CTRL = 4'h0
)
(
    input  wire logic              req_valid,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire lut_entry_t        entry,
    output mesh_req_t              formed
);

    localparam logic [7:0] PRIV_BASE = 8'(CORE_IN_CTRL * PRIV_SLOTS);

    always_comb begin
        formed        = '0;
        formed.valid  = req_valid;
        formed.kind   = entry.kind;
        formed.sel    = entry.sel;
        formed.fault  = req_valid && (entry.kind == DEST_NONE);
        formed.offset = req_addr[OFFSET_W-1:0];
        case (entry.kind)
            DEST_PRIVATE: begin
                formed.ctrl     = HOME_CTRL;
                formed.mem_slot = PRIV_BASE + {3'h0, entry.sel};
            end
            DEST_SHARED: begin
                formed.ctrl = entry.sel[1:0];
            end
            DEST_MSGBUF: begin
                formed.tile_x = 3'(entry.sel % 5'(MESH_X));
                formed.tile_y = 2'(entry.sel / 5'(MESH_X));
            end
            default: begin
                formed.ctrl = 2'h0;
            end
        endcase
    end

endmodule

// ===== rtl/core_address_lut.sv
/*
 * Per-core address lookup table: 256 slots of 16MB, each steered to a
 * destination on the mesh or flagged as a fault. Loads the 16GB default map under reset.
 * Assumes the core presents synchronous requests on clk_sys and that the
 * mesh side always accepts the registered request one cycle later.
 */
`timescale 1ns/1ps

// Contract
// - Table holds exactly 256 entries per core
// - Each entry covers its own 16MB range
// - Entries 0 to 19 map private memory
// - Entry 255 also maps private memory
// - Entry 251 maps voltage regulator controller
// - Entry 250 maps management console host
// - Entries 224-247 map tile config, tile rising
// - Entries 192-215 map message buffers, x fastest
// - Entries 128-131 map shared memory controllers 0-3
// - Private allotment whole slots of controller 4GB
module core_address_lut
    import lut_pkg::*;
#(
    parameter logic [1:0] HOME_CTRL    = 2'h0,
    parameter logic [3:0] CORE_IN_CTRL = 4'h0
)
(
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    input  wire core_req_t          core_req,
    input  wire logic               wr_valid,
    input  wire logic [INDEX_W-1:0] wr_index,
    input  wire lut_entry_t         wr_entry,
    output mesh_req_t               mesh_req
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        lut_entry_t [ENTRIES-1:0] slots;
        logic                     edited;
        mesh_req_t                out;
    } lut_state_t;

    localparam logic [7:0] PRIV_BASE = 8'(CORE_IN_CTRL * PRIV_SLOTS);

    lut_state_t               st_reg;
    lut_state_t               st_next;
    lut_entry_t [ENTRIES-1:0] default_table;
    lut_entry_t               hit_entry;
    mesh_req_t                formed;
    logic [INDEX_W-1:0]       req_index;

    ////////////////////////////////////////////////////////////////////////
    // Default map and request forming

    lut_default_map u_default_map (
        .default_table (default_table)
    );

    assign req_index = core_req.addr[ADDR_W-1:OFFSET_W];
    assign hit_entry = st_reg.slots[req_index];

    mesh_request_former #(
        .HOME_CTRL    (HOME_CTRL),
        .CORE_IN_CTRL (CORE_IN_CTRL)
    ) u_former (
        .req_valid (core_req.valid),
        .req_addr  (core_req.addr),
        .entry     (hit_entry),
        .formed    (formed)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_next     = st_reg;
        st_next.out = formed;
        if (wr_valid) begin
            st_next.slots[wr_index] = wr_entry;
            st_next.edited          = 1'b1;
        end
        if (!rst_b) begin
            st_next.slots  = default_table;
            st_next.edited = 1'b0;
            st_next.out    = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        st_reg <= st_next;
    end

    assign mesh_req = st_reg.out;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys);
    endclocking

    default disable iff (!rst_b);

    sequence s_fresh_req;
        core_req.valid && !st_reg.edited && !wr_valid;
    endsequence

    sequence s_fresh_at(logic [7:0] idx);
        s_fresh_req ##0 (core_req.addr[31:24] == idx);
    endsequence

    sequence s_fresh_in(logic [7:0] lo, logic [7:0] hi);
        s_fresh_req ##0 (core_req.addr[31:24] >= lo)
            ##0 (core_req.addr[31:24] <= hi);
    endsequence

    a_offset_pass: assert property (
        core_req.valid |=> mesh_req.valid
            && mesh_req.offset == $past(core_req.addr[23:0])
    ) else $error("offset not passed through");

    a_default_table: assert property (
        s_fresh_req |=> mesh_req.kind
            == default_table[$past(core_req.addr[31:24])].kind
            && mesh_req.fault == (mesh_req.kind == DEST_NONE)
    ) else $error("lookup disagrees with default map");

    a_slot_span: assert property (
        s_fresh_req ##1 (s_fresh_req ##0
            (core_req.addr[31:24] == $past(core_req.addr[31:24])))
        |=> mesh_req.kind == $past(mesh_req.kind)
            && mesh_req.sel == $past(mesh_req.sel)
    ) else $error("one slot gave two destinations");

    a_reset_load: assert property (
        disable iff (1'b0)
        !rst_b |=> !st_reg.edited && !mesh_req.valid
            && st_reg.slots[0].kind == DEST_PRIVATE
            && st_reg.slots[19].kind == DEST_PRIVATE
            && st_reg.slots[20].kind == DEST_NONE
    ) else $error("reset did not load default map");

    a_low_private: assert property (
        s_fresh_in(8'h00, 8'h13) |=> mesh_req.kind == DEST_PRIVATE
            && mesh_req.mem_slot == PRIV_BASE + $past(core_req.addr[31:24])
    ) else $error("low slot not private");

    a_top_private: assert property (
        s_fresh_at(PRIV_TOP_ENTRY) |=> mesh_req.kind == DEST_PRIVATE
            && mesh_req.mem_slot == PRIV_BASE + PRIV_LOW_COUNT
    ) else $error("top slot not private");

    a_vreg_slot: assert property (
        s_fresh_in(8'hf8, 8'hfe) |=> (mesh_req.kind == DEST_VREG)
            == ($past(core_req.addr[31:24]) == 8'hfb)
    ) else $error("regulator slot misplaced");

    a_console_slot: assert property (
        s_fresh_in(8'hf8, 8'hfe) |=> (mesh_req.kind == DEST_CONSOLE)
            == ($past(core_req.addr[31:24]) == 8'hfa)
    ) else $error("console slot misplaced");

    a_syscfg_tile: assert property (
        s_fresh_in(SYSCFG_FIRST, SYSCFG_LAST) |=>
            mesh_req.kind == DEST_SYSCFG
            && {3'h0, mesh_req.sel} + SYSCFG_FIRST
               == $past(core_req.addr[31:24])
    ) else $error("config tile number wrong");

    a_msgbuf_coord: assert property (
        s_fresh_in(MSGBUF_FIRST, MSGBUF_LAST) |=> mesh_req.kind == DEST_MSGBUF
            && mesh_req.tile_x < 3'h6
            && 8'(mesh_req.tile_y * 6 + mesh_req.tile_x) + MSGBUF_FIRST
               == $past(core_req.addr[31:24])
    ) else $error("message buffer tile wrong");

    a_shared_ctrl: assert property (
        s_fresh_in(SHARED_FIRST, SHARED_LAST) |=>
            mesh_req.kind == DEST_SHARED
            && {6'h00, mesh_req.ctrl} + SHARED_FIRST
               == $past(core_req.addr[31:24])
    ) else $error("shared controller wrong");

    a_private_home: assert property (
        s_fresh_req ##1 (mesh_req.kind == DEST_PRIVATE) |->
            mesh_req.ctrl == HOME_CTRL
            && mesh_req.mem_slot >= PRIV_BASE
            && mesh_req.mem_slot < PRIV_BASE + 8'(PRIV_SLOTS)
    ) else $error("private slot outside core allotment");

endmodule

// ===== dv/core_model.sv
/*
 * Model of the core that issues physical addresses to the lookup table.
 * Assumes the bench calls its tasks just after a rising edge of clk_sys.
 */
`timescale 1ns/1ps

module core_model
    import lut_pkg::*;
(
    input  wire logic clk_sys,
    output core_req_t core_req
);

    ////////////////////////////////////////////////////////////////////////
    // Request drive
    initial begin
        core_req = '0;
    end

    task automatic issue(input logic [ADDR_W-1:0] a);
        core_req.valid = 1'b1;
        core_req.addr  = a;
    endtask

    task automatic idle;
        core_req.valid = 1'b0;
    endtask

    // Idle address keeps toggling so stale values never pass for a request
    always @(posedge clk_sys) begin
        if (!core_req.valid) begin
            core_req.addr <= ~core_req.addr;
        end
    end

endmodule

// ===== dv/test_core_address_lut.sv
/*
 * Self-checking bench for the core address lookup table.
 * Assumes a 16GB default map and one-cycle registered lookups.
 */
`timescale 1ns/1ps

`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin \
    n_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
    end end

module test_core_address_lut;
    import lut_pkg::*;

    localparam logic [1:0] HOME = 2'h2;
    localparam logic [3:0] CIC  = 4'hb;

    logic               clk_sys;
    logic               rst_b;
    logic               wr_valid;
    logic [INDEX_W-1:0] wr_index;
    lut_entry_t         wr_entry;
    core_req_t          core_req;
    mesh_req_t          mesh_req;
    mesh_req_t          e;
    int                 n_errors;
    int                 compares;

    ////////////////////////////////////////////////////////////////////////
    // Design and core
    core_address_lut #(.HOME_CTRL(HOME), .CORE_IN_CTRL(CIC)) dut_u (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .core_req(core_req),
        .wr_valid(wr_valid),
        .wr_index(wr_index),
        .wr_entry(wr_entry),
        .mesh_req(mesh_req)
    );

    core_model core_u (
        .clk_sys (clk_sys),
        .core_req(core_req)
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    // Expected default answer
    function automatic mesh_req_t expect_req(input logic [ADDR_W-1:0] a);
        logic [7:0] i;
        mesh_req_t  r;
        i = a[31:24];
        r = '0;
        r.valid = 1'b1;
        r.offset = a[23:0];
        if (i < 8'd20 || i == 8'd255) begin
            r.kind = DEST_PRIVATE;
            r.sel = (i == 8'd255) ? 5'd20 : i[4:0];
            r.ctrl = HOME;
            r.mem_slot = 8'(CIC) * 8'd21 + {3'h0, r.sel};
        end else if (i >= 8'd128 && i <= 8'd131) begin
            r.kind = DEST_SHARED;
            r.sel = 5'(i - 8'd128);
            r.ctrl = 2'(i - 8'd128);
        end else if (i >= 8'd192 && i <= 8'd215) begin
            r.kind = DEST_MSGBUF;
            r.sel = 5'(i - 8'd192);
            r.tile_x = 3'((i - 8'd192) % 8'd6);
            r.tile_y = 2'((i - 8'd192) / 8'd6);
        end else if (i >= 8'd224 && i <= 8'd247) begin
            r.kind = DEST_SYSCFG;
            r.sel = 5'(i - 8'd224);
        end else if (i == 8'd250) begin
            r.kind = DEST_CONSOLE;
        end else if (i == 8'd251) begin
            r.kind = DEST_VREG;
        end else begin
            r.fault = 1'b1;
        end
        return r;
    endfunction

    task automatic step;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic lookup(input logic [ADDR_W-1:0] a);
        core_u.issue(a);
        step;
        `CHECK(mesh_req, expect_req(a))
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic scan_map;
        for (int k = 0; k < 256; k++) begin
            lookup({8'(k), (k % 2 == 1) ? 24'hffffff : 24'h000000});
        end
        lookup(32'h13a5a5a5);
        lookup(32'h14000000);
        lookup(32'hff123456);
        lookup(32'hfb001234);
        lookup(32'hfa00ffff);
        lookup(32'hf7800000);
        lookup(32'hd2000001);
        lookup(32'h83fffffe);
        core_u.idle;
        step;
        `CHECK(mesh_req.valid, 1'b0)
    endtask

    task automatic write_entry;
        wr_valid = 1'b1;
        wr_index = 8'h05;
        wr_entry = '{DEST_SHARED, 5'h02};
        lookup(32'h05abcdef);
        wr_index = 8'hff;
        wr_entry = ENTRY_NONE;
        core_u.issue(32'h05000010);
        step;
        wr_valid = 1'b0;
        e = '0;
        e.valid = 1'b1;
        e.kind = DEST_SHARED;
        e.sel = 5'h02;
        e.ctrl = 2'h2;
        e.offset = 24'h000010;
        `CHECK(mesh_req, e)
        core_u.issue(32'hff000020);
        step;
        e = '0;
        e.valid = 1'b1;
        e.fault = 1'b1;
        e.offset = 24'h000020;
        `CHECK(mesh_req, e)
    endtask

    task automatic reset_restore;
        core_u.idle;
        rst_b = 1'b0;
        wr_valid = 1'b1;
        wr_index = 8'h00;
        wr_entry = ENTRY_NONE;
        step;
        `CHECK(mesh_req, mesh_req_t'('0))
        rst_b = 1'b1;
        wr_valid = 1'b0;
        lookup(32'h00000000);
        lookup(32'h05000000);
        lookup(32'hffffffff);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Run control
    task automatic complete_run;
        if (n_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        n_errors++;
        complete_run;
    end

    initial begin
        n_errors = 0;
        compares = 0;
        rst_b = 1'b0;
        wr_valid = 1'b0;
        wr_index = '0;
        wr_entry = ENTRY_NONE;
        repeat (20) @(posedge clk_sys);
        #1;
        `CHECK(mesh_req, mesh_req_t'('0))
        rst_b = 1'b1;
        scan_map;
        write_entry;
        reset_restore;
        complete_run;
    end

endmodule
